//--- ime_map.vh
// constants for the two-wire transaction engine: pins, timing, encodings
`ifndef IME_MAP_VH
`define IME_MAP_VH

// pin bank and pin selection
`define IME_PIN_COUNT      16
`define IME_SEL_HI_BIT     3
`define IME_SDA_PIN_LO     4'h0
`define IME_SDA_PIN_HI     4'h8

// address modes: none, high byte only, high then low byte
`define IME_AMODE_NONE     2'h0
`define IME_AMODE_HIGH     2'h1
`define IME_AMODE_WORD     2'h2

// identity byte layout
`define IME_DIR_BIT        0
`define IME_DIR_WRITE      1'h0
`define IME_DIR_READ       1'h1

// connection attempts before giving up
`define IME_ATTEMPT_LAST   3'h7

// link timing: one quarter of a bit period
`define IME_CLK_NS         100
`define IME_QTR_NS         2500
`define IME_QTR_CYC        ((`IME_QTR_NS + `IME_CLK_NS - 1) / `IME_CLK_NS)

`endif

//--- ime_engine.v
// single-master two-wire transaction engine with combined-format reads
`timescale 1ns/1ps
`include "ime_map.vh"

// What this block does
// - every transfer is a whole eight-bit byte
// - identity byte: seven id bits, direction lsb
// - optional internal address byte follows identity
// - word address: high byte then low byte
// - data bytes follow the address, 0..255; a read of 0 reads 1
// - start and stop generated automatically
// - ninth clock per byte carries acknowledge
// - reads with an address: write id, address, read id
// - sole master, no arbitration, never target
// - pin select 0 or 8, clock next
// - both pins released when transaction ends
// - identity and address bytes are 0..255
// - eight connection attempts, then timeout
module ime_engine
(
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // transaction request
  input  wire        start_in,
  input  wire        read_transaction_in,
  input  wire [7:0]  target_identity_byte_in,
  input  wire [1:0]  addr_mode_in,
  input  wire [7:0]  address_high_byte_in,
  input  wire [7:0]  address_low_byte_in,
  input  wire [7:0]  byte_count_in,
  input  wire [3:0]  pin_sel_in,
  // outgoing data list
  input  wire [7:0]  tx_data_in,
  input  wire        tx_valid_in,
  output wire        tx_taken_out,
  // receive destination
  output wire [7:0]  rx_data_out,
  output wire        rx_valid_out,
  // status
  output wire        busy_out,
  output wire        done_out,
  output wire        timeout_out,
  output wire        nack_out,
  // pin bank, open drain
  input  wire [15:0] pin_in,
  output wire [15:0] pin_out,
  output wire [15:0] pin_oe_out
);

  // engine states, one-hot
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_BIT   = 5'h04;
  localparam [4:0] S_FETCH = 5'h08;
  localparam [4:0] S_STOP  = 5'h10;

  // byte steps of a transaction, one-hot
  localparam [5:0] T_ID1 = 6'h01;
  localparam [5:0] T_ADH = 6'h02;
  localparam [5:0] T_ADL = 6'h04;
  localparam [5:0] T_ID2 = 6'h08;
  localparam [5:0] T_WR  = 6'h10;
  localparam [5:0] T_RD  = 6'h20;

  localparam [31:0] QTR_LAST = `IME_QTR_CYC - 1;

  reg [4:0]  state_ff;
  reg [5:0]  step_ff;
  reg [1:0]  ph_ff;
  reg [4:0]  qcnt_ff;
  reg [3:0]  bit_ff;
  reg [7:0]  sh_ff;
  reg        ack_ff;
  reg [2:0]  att_ff;
  reg        retry_ff;
  reg        tout_ff;
  reg        err_ff;
  reg [7:0]  cnt_ff;
  reg        rd_ff;
  reg [7:0]  id_ff;
  reg [1:0]  amode_ff;
  reg [7:0]  adh_ff;
  reg [7:0]  adl_ff;
  reg        sel_hi_ff;
  reg [15:0] pin_s1_ff;
  reg [15:0] pin_s2_ff;
  reg [15:0] pin_oe_ff;
  reg [15:0] pin_out_ff;
  reg        tx_taken_ff;
  reg [7:0]  rx_data_ff;
  reg        rx_valid_ff;
  reg        busy_ff;
  reg        done_ff;
  reg        tout_out_ff;
  reg        nack_ff;
  reg        sda_low;
  reg        scl_low;

  // data pin index from the select; clock pin is the next one
  function [3:0] sda_index;
    input sel_hi;
    begin
      sda_index = sel_hi ? `IME_SDA_PIN_HI : `IME_SDA_PIN_LO;
    end
  endfunction

  wire [3:0] sda_idx = sda_index(sel_hi_ff);
  wire [3:0] scl_idx = sda_idx + 4'h1;
  wire       sda_s   = pin_s2_ff[sda_idx];
  wire       scl_s   = pin_s2_ff[scl_idx];

  // read without address goes straight to the read identity
  wire       rd_direct  = rd_ff && (amode_ff == `IME_AMODE_NONE);
  wire [5:0] first_step = rd_direct ? T_ID2 : T_ID1;
  wire [7:0] first_byte = {id_ff[7:1], rd_direct ? `IME_DIR_READ : `IME_DIR_WRITE};
  wire       last_rd    = (cnt_ff == 8'h01);

  // quarter tick; in quarter 1, with the clock released, wait for it to read high
  wire counting = (state_ff == S_START) || (state_ff == S_BIT) || (state_ff == S_STOP);
  wire tick     = counting && (qcnt_ff == QTR_LAST[4:0]) && ((ph_ff != 2'h1) || scl_s);

  // line drive per state and quarter, low or released only
  always @*
  begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    case (state_ff)
      S_START:
      begin
        sda_low = ph_ff[1];
        scl_low = (ph_ff == 2'h0) || (ph_ff == 2'h3);
      end
      S_BIT:
      begin
        scl_low = (ph_ff == 2'h0) || (ph_ff == 2'h3);
        if (bit_ff == 4'h8)
          sda_low = (step_ff == T_RD) && !last_rd;
        else
          sda_low = (step_ff != T_RD) && !sh_ff[7];
      end
      S_FETCH:
      begin
        scl_low = 1'b1; // hold the clock low while data is awaited
      end
      S_STOP:
      begin
        sda_low = !ph_ff[1];
        scl_low = (ph_ff == 2'h0);
      end
      default:
      begin
        sda_low = 1'b0;
        scl_low = 1'b0;
      end
    endcase
  end

  // pin bank: two-flop synchroniser in, registered enables out
  genvar gi;
  generate
    for (gi = 0; gi < `IME_PIN_COUNT; gi = gi + 1)
    begin : g_pin
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          pin_s1_ff[gi]  <= 1'b1;
          pin_s2_ff[gi]  <= 1'b1;
          pin_oe_ff[gi]  <= 1'b0;
          pin_out_ff[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_ff[gi]  <= pin_in[gi];
          pin_s2_ff[gi]  <= pin_s1_ff[gi];
          pin_oe_ff[gi]  <= (sda_low && (sda_idx == gi)) || (scl_low && (scl_idx == gi));
          pin_out_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // quarter-period counter, restarts every tick
  always @(posedge clk_in)
  begin
    if (rst_in || !counting || tick)
      qcnt_ff <= 5'h00;
    else if (qcnt_ff != QTR_LAST[4:0])
      qcnt_ff <= qcnt_ff + 5'h01;
  end

  // transaction sequencer; no arbitration, no target role
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff    <= S_IDLE;
      step_ff     <= T_ID1;
      ph_ff       <= 2'h0;
      bit_ff      <= 4'h0;
      sh_ff       <= 8'h00;
      ack_ff      <= 1'b0;
      att_ff      <= 3'h0;
      retry_ff    <= 1'b0;
      tout_ff     <= 1'b0;
      err_ff      <= 1'b0;
      cnt_ff      <= 8'h00;
      rd_ff       <= 1'b0;
      id_ff       <= 8'h00;
      amode_ff    <= 2'h0;
      adh_ff      <= 8'h00;
      adl_ff      <= 8'h00;
      sel_hi_ff   <= 1'b0;
      tx_taken_ff <= 1'b0;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      tout_out_ff <= 1'b0;
      nack_ff     <= 1'b0;
    end
    else
    begin
      tx_taken_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      done_ff     <= 1'b0;
      tout_out_ff <= 1'b0;
      nack_ff     <= 1'b0;
      if (tick)
        ph_ff <= ph_ff + 2'h1;
      case (state_ff)
        S_IDLE:
        begin
          if (start_in)
          begin
            rd_ff     <= read_transaction_in;
            id_ff     <= target_identity_byte_in;
            amode_ff  <= addr_mode_in;
            adh_ff    <= address_high_byte_in;
            adl_ff    <= address_low_byte_in;
            sel_hi_ff <= pin_sel_in[`IME_SEL_HI_BIT];
            cnt_ff    <= (read_transaction_in && (byte_count_in == 8'h00)) ? 8'h01
                                                                           : byte_count_in;
            att_ff    <= 3'h0;
            retry_ff  <= 1'b1;
            tout_ff   <= 1'b0;
            err_ff    <= 1'b0;
            busy_ff   <= 1'b1;
            state_ff  <= S_STOP;
            ph_ff     <= 2'h3; // enters the attempt path below at once
          end
        end
        S_START:
        begin
          if (tick && (ph_ff == 2'h3))
          begin
            state_ff <= S_BIT;
            bit_ff   <= 4'h0;
          end
        end
        S_FETCH:
        begin
          if (tx_valid_in)
          begin
            sh_ff       <= tx_data_in;
            tx_taken_ff <= 1'b1;
            bit_ff      <= 4'h0;
            ph_ff       <= 2'h0;
            state_ff    <= S_BIT;
          end
        end
        S_BIT:
        begin
          if (tick && (ph_ff == 2'h1))
          begin
            if (bit_ff == 4'h8)
              ack_ff <= !sda_s;
            else if (step_ff == T_RD)
              sh_ff <= {sh_ff[6:0], sda_s};
          end
          if (tick && (ph_ff == 2'h3))
          begin
            if (bit_ff != 4'h8)
            begin
              bit_ff <= bit_ff + 4'h1;
              if (step_ff != T_RD)
                sh_ff <= {sh_ff[6:0], 1'b0};
            end
            else
            begin
              bit_ff <= 4'h0;
              case (step_ff)
                T_ID1, T_ID2:
                begin
                  if (!ack_ff)
                  begin
                    state_ff <= S_STOP;
                    if (att_ff == `IME_ATTEMPT_LAST)
                      tout_ff <= 1'b1;
                    else
                    begin
                      retry_ff <= 1'b1;
                      att_ff   <= att_ff + 3'h1;
                    end
                  end
                  else if (step_ff == T_ID2)
                    step_ff <= T_RD;
                  else if (amode_ff != `IME_AMODE_NONE)
                  begin
                    step_ff <= T_ADH;
                    sh_ff   <= adh_ff;
                  end
                  else
                  begin
                    step_ff  <= T_WR;
                    state_ff <= (cnt_ff == 8'h00) ? S_STOP : S_FETCH;
                  end
                end
                T_ADH, T_ADL:
                begin
                  if (!ack_ff)
                  begin
                    err_ff   <= 1'b1;
                    state_ff <= S_STOP;
                  end
                  else if ((step_ff == T_ADH) && (amode_ff[1] == 1'b1))
                  begin
                    step_ff <= T_ADL;
                    sh_ff   <= adl_ff;
                  end
                  else if (rd_ff)
                  begin
                    step_ff  <= T_ID2;
                    sh_ff    <= {id_ff[7:1], `IME_DIR_READ};
                    state_ff <= S_START;
                  end
                  else
                  begin
                    step_ff  <= T_WR;
                    state_ff <= (cnt_ff == 8'h00) ? S_STOP : S_FETCH;
                  end
                end
                T_WR:
                begin
                  cnt_ff <= cnt_ff - 8'h01;
                  if (!ack_ff)
                  begin
                    err_ff   <= 1'b1;
                    state_ff <= S_STOP;
                  end
                  else
                    state_ff <= last_rd ? S_STOP : S_FETCH;
                end
                default:
                begin
                  rx_data_ff  <= sh_ff;
                  rx_valid_ff <= 1'b1;
                  cnt_ff      <= cnt_ff - 8'h01;
                  if (last_rd)
                    state_ff <= S_STOP;
                end
              endcase
            end
          end
        end
        default:
        begin
          // stop; also the launch point of each connection attempt
          if ((tick || !busy_ff || retry_ff) && (ph_ff == 2'h3) && (tick || !counting
              || retry_ff))
          begin
            if (retry_ff)
            begin
              retry_ff <= 1'b0;
              step_ff  <= first_step;
              sh_ff    <= first_byte;
              ph_ff    <= 2'h0;
              state_ff <= S_START;
            end
            else
            begin
              state_ff    <= S_IDLE;
              busy_ff     <= 1'b0;
              done_ff     <= 1'b1;
              tout_out_ff <= tout_ff;
              nack_ff     <= err_ff;
            end
          end
        end
      endcase
    end
  end

  assign tx_taken_out = tx_taken_ff;
  assign rx_data_out  = rx_data_ff;
  assign rx_valid_out = rx_valid_ff;
  assign busy_out     = busy_ff;
  assign done_out     = done_ff;
  assign timeout_out  = tout_out_ff;
  assign nack_out     = nack_ff;
  assign pin_out      = pin_out_ff;
  assign pin_oe_out   = pin_oe_ff;

endmodule // ime_engine

//--- ime_engine_properties.sv
// port assertions for the two-wire transaction engine
`timescale 1ns/1ps
module ime_engine_properties
(
  // clock, reset and requests
  input wire        clk_in,
  input wire        rst_in,
  input wire        start_in,
  input wire        tx_valid_in,
  input wire [3:0]  pin_sel_in,
  // engine outputs
  input wire        tx_taken_out,
  input wire        rx_valid_out,
  input wire        busy_out,
  input wire        done_out,
  input wire        timeout_out,
  input wire        nack_out,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe_out
);
  reg        stop_seen_ff;
  wire [3:0] dp   = {pin_sel_in[3], 3'h0};
  wire       oe_d = pin_oe_out[dp];
  wire       oe_c = pin_oe_out[dp + 4'h1];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence take_s;
    start_in && !busy_out;
  endsequence
  sequence idle_s;
    !busy_out && !done_out;
  endsequence
  // data released while clock released marks a stop
  always @(posedge clk_in)
    if (rst_in || (start_in && !busy_out))
      stop_seen_ff <= 1'b0;
    else if (!oe_c && $fell(oe_d))
      stop_seen_ff <= 1'b1;
  drive_low_a: assert property (pin_out == 16'h0)
    else $error("pin driven high");
  pair_only_a: assert property ((pin_oe_out & ~(16'h3 << dp)) == 16'h0)
    else $error("pin outside pair");
  busy_rise_a: assert property (take_s |=> busy_out [*2])
    else $error("request not taken");
  done_free_a: assert property (done_out |-> !busy_out && pin_oe_out == 16'h0)
    else $error("pins held at done");
  idle_free_a: assert property (idle_s |-> pin_oe_out == 16'h0)
    else $error("pins held when idle");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done too long");
  stop_first_a: assert property (done_out |-> stop_seen_ff)
    else $error("done without stop");
  flag_done_a: assert property (timeout_out || nack_out |-> done_out)
    else $error("flag without done");
  take_valid_a: assert property (tx_taken_out |-> $past(tx_valid_in) && $past(oe_c))
    else $error("bad data take");
  rx_busy_a: assert property (rx_valid_out |-> busy_out && !done_out)
    else $error("stray receive");
endmodule // ime_engine_properties
bind ime_engine ime_engine_properties u_chk
(
  .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .tx_valid_in(tx_valid_in),
  .pin_sel_in(pin_sel_in), .tx_taken_out(tx_taken_out), .rx_valid_out(rx_valid_out),
  .busy_out(busy_out), .done_out(done_out), .timeout_out(timeout_out),
  .nack_out(nack_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out)
);

//--- ime_target_model.sv
// behavioural two-wire target: acks its identity, logs bytes, serves reads
`timescale 1ns/1ps
module ime_target_model
#(
  parameter [6:0] ID = 7'h2A
)
(
  // wires as seen after the pull-ups
  input  wire  scl_in,
  input  wire  sda_in,
  // pulls the data wire low
  output logic sda_low_out
);
  logic [7:0] log_q[$];
  logic [7:0] sh, rb;
  int         k, nb, starts, macks;
  bit         act, tx, rdp;
  // set by the bench: refuse every byte after the identity
  bit         refuse;
  initial sda_low_out = 1'b0;
  // start: data falls while clock high
  always @(negedge sda_in)
    if (scl_in === 1'b1)
    begin
      starts++;
      act = 1;
      tx = 0;
      rdp = 0;
      k = 0;
      nb = 0;
    end
  // stop: data rises while clock high
  always @(posedge sda_in)
    if (scl_in === 1'b1)
      act = 0;
  // sample on rising clock, ninth clock is the acknowledge
  always @(posedge scl_in)
    if (act)
    begin
      if (k < 8)
        sh = {sh[6:0], sda_in};
      else if (tx && sda_in)
        tx = 0;
      else if (tx)
      begin
        macks++;
        rb++;
      end
      else if (rdp)
      begin
        tx = 1;
        rb = 8'hC0;
      end
      k = (k == 8) ? 0 : k + 1;
    end
  // drive on falling clock so data moves only while clock low
  always @(negedge scl_in)
    if (act)
    begin
      sda_low_out = 0;
      if (k == 8 && !tx)
      begin
        if ((nb == 0 && sh[7:1] != ID) || (nb > 0 && refuse))
          act = 0;
        else
        begin
          sda_low_out = 1;
          log_q.push_back(sh);
          rdp = rdp || (nb == 0 && sh[0]);
        end
        nb++;
      end
      else if (tx && k < 8)
        sda_low_out = !rb[7 - k];
    end
endmodule // ime_target_model

//--- ime_engine_tb.sv
// self-checking bench: engine against a behavioural target
`timescale 1ns/1ps
module ime_engine_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  am = 2'h0;
  logic [7:0]  idb = 8'h55;
  logic [7:0]  bc = 8'h01;
  logic [7:0]  txd = 8'h5A;
  logic [3:0]  sel = 4'h0;
  logic        txv = 1'b1;
  wire  [7:0]  rxd;
  wire  [15:0] oe, pins;
  wire         tk, rxv, busy, done, tmo, nak, t_low;
  wire  [3:0]  dp = {sel[3], 3'h0};
  int          err_total, samples_checked, ntx, c;
  logic [7:0]  rx_q[$];
  // pull-ups: a wire is low only where someone pulls it
  assign pins = ~oe & ~({15'h0, t_low} << dp);
  always #50 clk_in = ~clk_in;
  ime_engine u_dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .read_transaction_in(rd),
    .target_identity_byte_in(idb), .addr_mode_in(am), .address_high_byte_in(8'h08),
    .address_low_byte_in(8'h02), .byte_count_in(bc), .pin_sel_in(sel), .tx_data_in(txd),
    .tx_valid_in(txv), .tx_taken_out(tk), .rx_data_out(rxd), .rx_valid_out(rxv),
    .busy_out(busy), .done_out(done), .timeout_out(tmo), .nack_out(nak), .pin_in(pins),
    .pin_out(), .pin_oe_out(oe)
  );
  ime_target_model u_tgt
  (
    .scl_in(pins[dp + 4'h1]), .sda_in(pins[dp]), .sda_low_out(t_low)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_q(input logic [7:0] g[$], input logic [7:0] e[$]);
    chk(16'(g.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h0, g[i]}, {8'h0, e[i]});
  endtask
  // one transaction; a second request while busy must vanish
  // f is the expected {timeout, nack} pair at done
  task automatic run(input logic r, input logic [1:0] m, input logic [7:0] n,
                     input logic [1:0] f);
    // a clock edge between transfers, so no signal is driven twice at once
    @(negedge clk_in);
    rx_q.delete();
    u_tgt.log_q.delete();
    u_tgt.starts = 0;
    u_tgt.macks = 0;
    ntx = 0;
    {rd, am, bc, start_in, txd, txv} = {r, m, n, 1'b1, 8'h5A, 1'b1};
    for (c = 0; c < 20000 && !done; c++)
    begin
      @(negedge clk_in);
      start_in = (c == 300);
      ntx += tk;
      txd += 8'(tk);
      // valid drops after each take and comes back late, so the engine stretches
      if (tk)
        txv = 1'b0;
      else if (c % 4096 == 4095)
        txv = 1'b1;
      if (rxv) rx_q.push_back(rxd);
    end
    if (c >= 20000)
    begin
      err_total++;
      end_of_test();
    end
    chk(oe, 16'h0);
    chk({14'h0, tmo, nak}, {14'h0, f});
  endtask
  task automatic t_write();
    sel = 4'h0;
    run(1'b0, 2'h2, 8'h02, 2'h0);
    chk_q(u_tgt.log_q, {8'h54, 8'h08, 8'h02, 8'h5A, 8'h5B});
    chk(16'(ntx), 16'h2);
    chk(16'(u_tgt.starts), 16'h1);
    $display("write test done");
  endtask
  task automatic t_read();
    sel = 4'h8;
    idb = 8'h54;
    run(1'b1, 2'h1, 8'h03, 2'h0);
    chk_q(u_tgt.log_q, {8'h54, 8'h08, 8'h55});
    chk_q(rx_q, {8'hC0, 8'hC1, 8'hC2});
    chk(16'(u_tgt.macks), 16'h2);
    chk(16'(u_tgt.starts), 16'h2);
    $display("read test done");
  endtask
  task automatic t_zero();
    run(1'b0, 2'h3, 8'h00, 2'h0);
    chk_q(u_tgt.log_q, {8'h54, 8'h08, 8'h02});
    chk(16'(ntx), 16'h0);
    $display("empty write test done");
  endtask
  task automatic t_short();
    sel = 4'h0;
    run(1'b1, 2'h0, 8'h00, 2'h0);
    chk_q(u_tgt.log_q, {8'h55});
    chk_q(rx_q, {8'hC0});
    chk(16'(u_tgt.macks), 16'h0);
    $display("short read test done");
  endtask
  // target refuses the address byte: no retry, nack flag at done
  task automatic t_nack();
    u_tgt.refuse = 1'b1;
    run(1'b0, 2'h1, 8'h01, 2'h1);
    u_tgt.refuse = 1'b0;
    chk_q(u_tgt.log_q, {8'h54});
    chk(16'(ntx), 16'h0);
    chk(16'(u_tgt.starts), 16'h1);
    $display("address refusal test done");
  endtask
  task automatic t_tmo();
    idb = 8'h22;
    run(1'b1, 2'h2, 8'h02, 2'h2);
    chk(16'(u_tgt.starts), 16'h8);
    chk(16'(rx_q.size()), 16'h0);
    chk({8'h0, rxd}, 16'h00C0);
    $display("timeout test done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    t_write();
    t_read();
    t_zero();
    t_short();
    t_nack();
    t_tmo();
    end_of_test();
  end
endmodule // ime_engine_tb
